// ### verilog/vid_in_select_defines.vh
// Register map, field positions, reset values and timing constants of the video input select block.
`ifndef VID_IN_SELECT_DEFINES_VH
`define VID_IN_SELECT_DEFINES_VH
`define A_CTRL 5'h00
`define A_LAST_DATA 5'h04
`define A_STATUS 5'h08
`define A_IRQ_STATUS 5'h0c
`define A_IRQ_MASK 5'h10
`define A_TREAT 5'h14
`define RATE_AUTO 2'h0
`define RATE_525 2'h1
`define RATE_625 2'h2
`define CTRL_RATE_LO 0
`define CTRL_FLY 2
`define CTRL_SRC_VID 3
`define CTRL_REP_VID 4
`define CTRL_REP_REF 5
`define CTRL_RESET 6'h30
`define LAST_625_LO 8
`define LAST_RESET 11'h000
`define TREAT_RESET 12'h000
`define TR_BLANK 2'h1
`define TR_NOTCH 2'h2
`define TR_PASS 2'h0
`define TR_PICTURE 2'h3
`define IRQ_VID_LOSS 0
`define IRQ_REF_LOSS 1
`define IRQ_RATE_CHG 2
`define IRQ_FLY_DONE 3
`define FLY_TIME_S 9
`define MUTE_TIME_US 1000
`define CLK_MHZ 50
`define FLY_CYCLES (`FLY_TIME_S * 50000000)
`define MUTE_CYCLES (`MUTE_TIME_US * `CLK_MHZ)
`define L525_F1_FIRST 10'd21
`define L525_F1_LAST 10'd24
`define L525_F2_FIRST 10'd284
`define L525_F2_LAST 10'd287
`define L625_F1_FIRST 10'd24
`define L625_F1_LAST 10'd28
`define L625_F2_FIRST 10'd337
`define L625_F2_LAST 10'd341
`define V525_F1_FIRST 10'd10
`define V525_F2_FIRST 10'd273
`define V625_F1_FIRST 10'd6
`define V625_F2_FIRST 10'd319
`endif

// ### verilog/vid_in_select.v
// Video input select: line rate, signal presence, flywheel, output timing and data line reservation.
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "vid_in_select_defines.vh"

// Operation
// - Rate fixed 525, 625 or auto; detected rate reported.
// - Disabled loss reports hidden upstream, still shown locally.
// - Video format always reads composite, read-only.
// - Flywheel timing on/off completes after nine seconds.
// - Status shows frame sync or delay mode.
// - Output timing source: frame reference or video input.
// - Delay mode mutes audio on input switch.
// - Last data line setting reserves lines up to it.
// - 525: lines 21-24 and 284-287 eligible.
// - 625: lines 24-28 and 337-341 eligible.
// - Unreserved eligible lines stay ordinary picture lines.
// - Frame reference presence detected and reported.
// - Each VBI or data line blanked, notched or passed.
module vid_in_select #(
	parameter [31:0] FLY_CYCLES = `FLY_CYCLES,
	parameter [31:0] MUTE_CYCLES = `MUTE_CYCLES
) (
	// Clock, reset and enable.
	input wire CLK,
	input wire RST_B,
	input wire CE,
	// AHB-Lite slave.
	input wire HSEL,
	input wire [31:0] HADDR,
	input wire [1:0] HTRANS,
	input wire HWRITE,
	input wire [2:0] HSIZE,
	input wire [31:0] HWDATA,
	input wire HREADY,
	output wire HREADYOUT,
	output wire HRESP,
	output reg [31:0] HRDATA,
	// Pins from the video decoder front end and the frame reference.
	input wire VID_PRESENT,
	input wire REF_PRESENT,
	input wire VID_DET_625,
	// Video line position and input switching, same clock.
	input wire [9:0] LINE_NUM,
	input wire INPUT_SWITCH,
	// Control and status outputs.
	output reg RATE_625,
	output reg FLYWHEEL_ON,
	output reg FRAME_SYNC_MODE,
	output reg AUDIO_MUTE,
	output reg VID_LOS_REPORT,
	output reg REF_LOS_REPORT,
	output reg LINE_IS_DATA,
	output reg [1:0] LINE_TREAT,
	output wire IRQ
);

	// Index 1..5 of an eligible data line within its field, 0 when not eligible.
	// The offset from the first eligible line is at most four, so only its low three bits are kept.
	function [2:0] data_index;
		input [9:0] ln;
		input is625;
		reg [9:0] off;
		begin
			data_index = 3'h0;
			off = 10'h000;
			if (!is625) begin
				if (ln >= `L525_F1_FIRST && ln <= `L525_F1_LAST) begin
					off = ln - `L525_F1_FIRST;
					data_index = off[2:0] + 3'h1;
				end else if (ln >= `L525_F2_FIRST && ln <= `L525_F2_LAST) begin
					off = ln - `L525_F2_FIRST;
					data_index = off[2:0] + 3'h1;
				end
			end else begin
				if (ln >= `L625_F1_FIRST && ln <= `L625_F1_LAST) begin
					off = ln - `L625_F1_FIRST;
					data_index = off[2:0] + 3'h1;
				end else if (ln >= `L625_F2_FIRST && ln <= `L625_F2_LAST) begin
					off = ln - `L625_F2_FIRST;
					data_index = off[2:0] + 3'h1;
				end
			end
		end
	endfunction

	// True for the blanking interval lines ahead of the eligible data lines.
	function is_vbi;
		input [9:0] ln;
		input is625;
		begin
			if (!is625)
				is_vbi = (ln >= `V525_F1_FIRST && ln < `L525_F1_FIRST) ||
					(ln >= `V525_F2_FIRST && ln < `L525_F2_FIRST);
			else
				is_vbi = (ln >= `V625_F1_FIRST && ln < `L625_F1_FIRST) ||
					(ln >= `V625_F2_FIRST && ln < `L625_F2_FIRST);
		end
	endfunction

	// Pin synchronisers: three stages, a change counts once stages two and three agree.
	wire [2:0] pin_in = {VID_DET_625, REF_PRESENT, VID_PRESENT};
	reg [2:0] s1_r, s2_r, s3_r, pin_r;
	// Presence pins start as present, so no loss is reported before the first real sample.
	// A pin that is really absent then shows up as a loss once it has passed the synchroniser.
	localparam [2:0] PIN_RST = 3'b011;
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_sync
			always @(posedge CLK or negedge RST_B) begin
				if (!RST_B) begin
					s1_r[g] <= PIN_RST[g];
					s2_r[g] <= PIN_RST[g];
					s3_r[g] <= PIN_RST[g];
					pin_r[g] <= PIN_RST[g];
				end else if (CE) begin
					s1_r[g] <= pin_in[g];
					s2_r[g] <= s1_r[g];
					s3_r[g] <= s2_r[g];
					if (s2_r[g] == s3_r[g])
						pin_r[g] <= s3_r[g];
				end
			end
		end
	endgenerate
	wire vid_ok = pin_r[0];
	wire ref_ok = pin_r[1];
	wire det625 = pin_r[2];

	// Software registers.
	reg [5:0] ctrl_r;
	reg [10:0] last_r;
	reg [11:0] treat_r;
	reg [3:0] irq_st_r, irq_st_nxt;
	reg [3:0] irq_mask_r;
	reg [2:0] prev_r;
	reg [31:0] rd_nxt;

	// Bus data phase bookkeeping.
	// A write is taken in its address phase and lands at the end of its data phase, when the data stand.
	reg wr_pend_r;
	reg [4:0] wr_addr_r;
	// Wait states come only from a low clock enable, which also freezes every register.
	wire addr_ok = HSEL && HTRANS[1] && HREADY && CE;
	assign HREADYOUT = CE;
	assign HRESP = 1'b0;

	// Flywheel and mute sequencing.
	reg fly_busy_r;
	reg [31:0] fly_cnt_r;
	reg [31:0] mute_cnt_r;

	// Auto follows the synchronised detector; the spare rate code behaves as 525.
	wire [1:0] rate_sel = ctrl_r[`CTRL_RATE_LO+1:`CTRL_RATE_LO];
	wire rate_eff = (rate_sel == `RATE_AUTO) ? det625 : (rate_sel == `RATE_625);
	wire src_vid = ctrl_r[`CTRL_SRC_VID];
	wire [2:0] last_sel = rate_eff ? last_r[`LAST_625_LO+2:`LAST_625_LO] : last_r[2:0];
	wire [2:0] idx = data_index(LINE_NUM, rate_eff);
	wire reserved = (idx != 3'h0) && (idx <= last_sel);
	// Slot k sits in bits 2k-1 and 2k-2, so the shifted word carries it in its lowest two bits.
	wire [3:0] tsh = {idx - 3'h1, 1'b0};
	wire [11:0] treat_sh = treat_r >> tsh;
	wire [1:0] treat_slot = treat_sh[1:0];
	wire fly_done = fly_busy_r && (fly_cnt_r == FLY_CYCLES - 32'h1);
	wire vid_lost = prev_r[0] & ~vid_ok;
	wire ref_lost = prev_r[1] & ~ref_ok;
	wire rate_chg = det625 != prev_r[2];
	wire [3:0] events = {fly_done, rate_chg, ref_lost, vid_lost};
	// Writes above the largest index are clamped to the last eligible line of each rate.
	wire [2:0] last525_clamp = (HWDATA[2:0] > 3'h4) ? 3'h4 : HWDATA[2:0];
	wire [2:0] last625_clamp = (HWDATA[10:8] > 3'h5) ? 3'h5 : HWDATA[10:8];

	wire [31:0] status_w = {24'h0, AUDIO_MUTE, fly_busy_r, FLYWHEEL_ON, ~src_vid,
		ref_ok, vid_ok, 1'b1, det625};

	// Read data are chosen in the address phase; unmapped addresses read zero.
	always @* begin
		rd_nxt = 32'h0;
		if (HADDR[31:5] == 27'h0) begin
			case (HADDR[4:0])
			`A_CTRL: rd_nxt = {26'h0, ctrl_r};
			`A_LAST_DATA: rd_nxt = {21'h0, last_r};
			`A_STATUS: rd_nxt = status_w;
			`A_IRQ_STATUS: rd_nxt = {28'h0, irq_st_r};
			`A_IRQ_MASK: rd_nxt = {28'h0, irq_mask_r};
			`A_TREAT: rd_nxt = {20'h0, treat_r};
			default: rd_nxt = 32'h0;
			endcase
		end
	end

	// An event in the cycle of its clear wins, so no event is ever lost.
	always @* begin
		irq_st_nxt = irq_st_r;
		if (wr_pend_r && wr_addr_r == `A_IRQ_STATUS)
			irq_st_nxt = irq_st_nxt & ~HWDATA[3:0];
		irq_st_nxt = irq_st_nxt | events;
	end

	assign IRQ = |(irq_st_r & irq_mask_r);

	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_r <= `CTRL_RESET;
			last_r <= `LAST_RESET;
			treat_r <= `TREAT_RESET;
			irq_st_r <= 4'h0;
			irq_mask_r <= 4'h0;
			prev_r <= 3'h0;
			wr_pend_r <= 1'b0;
			wr_addr_r <= 5'h00;
			HRDATA <= 32'h0;
		end else if (CE) begin
			prev_r <= {det625, ref_ok, vid_ok};
			irq_st_r <= irq_st_nxt;
			wr_pend_r <= addr_ok && HWRITE;
			wr_addr_r <= HADDR[4:0];
			if (addr_ok && !HWRITE)
				HRDATA <= rd_nxt;
			if (addr_ok && HWRITE && HADDR[31:5] != 27'h0)
				wr_pend_r <= 1'b0;
			if (wr_pend_r) begin
				case (wr_addr_r)
				`A_CTRL: ctrl_r <= HWDATA[5:0];
				`A_LAST_DATA: last_r <= {last625_clamp, 5'h0, last525_clamp};
				`A_IRQ_MASK: irq_mask_r <= HWDATA[3:0];
				`A_TREAT: treat_r <= HWDATA[11:0];
				default: ;
				endcase
			end
		end
	end

	// Flywheel: a change of the request starts the settling count, a change back cancels it; the new state lands at its end.
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			FLYWHEEL_ON <= 1'b0;
			fly_busy_r <= 1'b0;
			fly_cnt_r <= 32'h0;
		end else if (CE) begin
			if (ctrl_r[`CTRL_FLY] != FLYWHEEL_ON && !fly_busy_r) begin
				fly_busy_r <= 1'b1;
				fly_cnt_r <= 32'h0;
			end else if (fly_busy_r) begin
				if (ctrl_r[`CTRL_FLY] == FLYWHEEL_ON) begin
					fly_busy_r <= 1'b0;
				end else if (fly_done) begin
					FLYWHEEL_ON <= ctrl_r[`CTRL_FLY];
					fly_busy_r <= 1'b0;
				end else begin
					fly_cnt_r <= fly_cnt_r + 32'h1;
				end
			end
		end
	end

	// Outputs: rate, mode, reports, audio mute and per-line treatment.
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			RATE_625 <= 1'b0;
			FRAME_SYNC_MODE <= 1'b1;
			AUDIO_MUTE <= 1'b0;
			mute_cnt_r <= 32'h0;
			VID_LOS_REPORT <= 1'b0;
			REF_LOS_REPORT <= 1'b0;
			LINE_IS_DATA <= 1'b0;
			LINE_TREAT <= `TR_PICTURE;
		end else if (CE) begin
			RATE_625 <= rate_eff;
			FRAME_SYNC_MODE <= ~src_vid;
			VID_LOS_REPORT <= ctrl_r[`CTRL_REP_VID] & ~vid_ok;
			REF_LOS_REPORT <= ctrl_r[`CTRL_REP_REF] & ~ref_ok;
			// A new switch while muted restarts the mute span.
			if (INPUT_SWITCH && src_vid) begin
				AUDIO_MUTE <= 1'b1;
				mute_cnt_r <= MUTE_CYCLES - 32'h1;
			end else if (mute_cnt_r != 32'h0) begin
				mute_cnt_r <= mute_cnt_r - 32'h1;
			end else begin
				AUDIO_MUTE <= 1'b0;
			end
			// A reserved line takes its own slot, a blanking line the shared slot, all else stays picture.
			LINE_IS_DATA <= reserved;
			if (reserved)
				LINE_TREAT <= treat_slot;
			else if (is_vbi(LINE_NUM, rate_eff))
				LINE_TREAT <= treat_r[11:10];
			else
				LINE_TREAT <= `TR_PICTURE;
		end
	end

endmodule // vid_in_select
`default_nettype wire

// ### testbench/vid_in_select_monitor.sv
// Assertion checker for the video input select block.
`timescale 1ns/1ps
`default_nettype none
module vid_in_select_monitor (
	// Clock and reset.
	input wire logic CLK,
	input wire logic RST_B,
	// Watched ports.
	input wire logic VID_PRESENT,
	input wire logic REF_PRESENT,
	input wire logic [9:0] LINE_NUM,
	input wire logic INPUT_SWITCH,
	input wire logic RATE_625,
	input wire logic FLYWHEEL_ON,
	input wire logic AUDIO_MUTE,
	input wire logic VID_LOS_REPORT,
	input wire logic REF_LOS_REPORT,
	input wire logic LINE_IS_DATA,
	input wire logic [1:0] LINE_TREAT
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	a_mute_cause: assert property ($rose(AUDIO_MUTE) |-> $past(INPUT_SWITCH)) else $error("stray mute");
	a_mute_span: assert property ($rose(AUDIO_MUTE) |-> AUDIO_MUTE[*8]) else $error("short mute");
	a_data_lines_525: assert property (LINE_IS_DATA && !RATE_625 && $stable(RATE_625)
		|-> $past(LINE_NUM) inside {[21:24], [284:287]}) else $error("bad 525 line");
	a_data_lines_625: assert property (LINE_IS_DATA && RATE_625 && $stable(RATE_625)
		|-> $past(LINE_NUM) inside {[24:28], [337:341]}) else $error("bad 625 line");
	a_picture_line: assert property (!LINE_IS_DATA && $stable(RATE_625) && !(RATE_625 ?
		$past(LINE_NUM) inside {[6:23], [319:336]} : $past(LINE_NUM) inside {[10:20], [273:283]})
		|-> LINE_TREAT == 2'h3) else $error("bad picture line");
	a_vid_report: assert property ($rose(VID_LOS_REPORT) |-> !$past(VID_PRESENT)) else $error("bad report");
	a_ref_report: assert property ($rose(REF_LOS_REPORT) |-> !$past(REF_PRESENT)) else $error("bad report");
	a_fly_hold: assert property ($changed(FLYWHEEL_ON) |=> $stable(FLYWHEEL_ON)[*8]) else $error("fast fly");
	c_mute: cover property ($rose(AUDIO_MUTE));
	c_data: cover property (LINE_IS_DATA && RATE_625);
	c_fly: cover property ($rose(FLYWHEEL_ON));
endmodule // vid_in_select_monitor
bind vid_in_select vid_in_select_monitor mon (.CLK(CLK), .RST_B(RST_B), .VID_PRESENT(VID_PRESENT),
	.REF_PRESENT(REF_PRESENT), .LINE_NUM(LINE_NUM), .INPUT_SWITCH(INPUT_SWITCH), .RATE_625(RATE_625),
	.FLYWHEEL_ON(FLYWHEEL_ON), .AUDIO_MUTE(AUDIO_MUTE), .VID_LOS_REPORT(VID_LOS_REPORT),
	.REF_LOS_REPORT(REF_LOS_REPORT), .LINE_IS_DATA(LINE_IS_DATA), .LINE_TREAT(LINE_TREAT));
`default_nettype wire

// ### testbench/video_source_model.sv
// Video source model: line counter of a 525 or 625 line frame and switch pulse.
`timescale 1ns/1ps
`default_nettype none
module video_source_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Commands.
	input wire logic is_625,
	input wire logic sw_req,
	// Pins toward the block.
	output logic [9:0] line_num,
	output logic input_switch
);
	logic sw_d;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			line_num <= 10'h001;
			sw_d <= 1'b0;
			input_switch <= 1'b0;
		end else begin
			line_num <= (line_num >= (is_625 ? 10'd625 : 10'd525)) ? 10'h001 : line_num + 10'h001;
			sw_d <= sw_req;
			input_switch <= sw_req && !sw_d;
		end
	end
endmodule // video_source_model
`default_nettype wire

// ### testbench/vid_in_select_tb.sv
// Self-checking bench for the video input select block.
`timescale 1ns/1ps
`default_nettype none
`include "vid_in_select_defines.vh"
module vid_in_select_tb;
	logic CLK = 0, RST_B = 0, HSEL = 0, HWRITE = 0, vid = 1, ref_in = 1, det = 1, sw = 0;
	logic [1:0] HTRANS = 0, tr;
	logic [31:0] HADDR = 0, HWDATA = 0, rd;
	wire logic HREADYOUT, HRESP, INPUT_SWITCH, RATE_625, FLYWHEEL_ON, FRAME_SYNC_MODE, AUDIO_MUTE, IRQ;
	wire logic VID_LOS_REPORT, REF_LOS_REPORT, LINE_IS_DATA;
	wire logic [1:0] LINE_TREAT;
	wire logic [9:0] LINE_NUM;
	wire logic [31:0] HRDATA;
	int fail_count = 0, comparisons = 0, n, k, i;
	always #10 CLK = ~CLK;
	vid_in_select #(.FLY_CYCLES(32'd20), .MUTE_CYCLES(32'd8)) dut (.CLK(CLK), .RST_B(RST_B), .CE(1'b1),
		.HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .VID_PRESENT(vid),
		.REF_PRESENT(ref_in), .VID_DET_625(det), .LINE_NUM(LINE_NUM), .INPUT_SWITCH(INPUT_SWITCH),
		.RATE_625(RATE_625), .FLYWHEEL_ON(FLYWHEEL_ON), .FRAME_SYNC_MODE(FRAME_SYNC_MODE),
		.AUDIO_MUTE(AUDIO_MUTE), .VID_LOS_REPORT(VID_LOS_REPORT), .REF_LOS_REPORT(REF_LOS_REPORT),
		.LINE_IS_DATA(LINE_IS_DATA), .LINE_TREAT(LINE_TREAT), .IRQ(IRQ));
	video_source_model src (.clk(CLK), .rst_b(RST_B), .is_625(det), .sw_req(sw), .line_num(LINE_NUM),
		.input_switch(INPUT_SWITCH));
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		HSEL <= 1;
		HTRANS <= 2'h2;
		HADDR <= a;
		HWRITE <= w;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		rd = HRDATA;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge CLK);
	endtask
	// Counts data lines over one frame and keeps the last data line treatment.
	task automatic frame(input int len);
		n = 0;
		repeat (len) begin
			@(posedge CLK);
			if (LINE_IS_DATA === 1'b1) begin
				n++;
				tr = LINE_TREAT;
			end
		end
	endtask
	task end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		cyc(16);
		RST_B <= 1;
		cyc(1);
		bus(0, `A_CTRL, 0);
		chk(rd, 32'h30);
		chk(HRESP, 1'b0);
		bus(1, `A_STATUS, 0);
		bus(0, `A_STATUS, 0);
		chk(rd & 32'h12, 32'h12);
		bus(0, 32'h18, 0);
		chk(rd, 0);
		$display("test registers done");
		for (i = 0; i < 3; i++) begin
			bus(1, `A_CTRL, 32'h30 | i);
			cyc(8);
			chk(RATE_625, i != 1);
		end
		$display("test rate done");
		for (i = 0; i < 2; i++) begin
			bus(1, `A_CTRL, 32'h31 + i);
			for (k = 0; k < 8; k++) begin
				bus(1, `A_LAST_DATA, i ? k << 8 : k);
				bus(1, `A_TREAT, (k % 3) * 32'h155);
				cyc(2);
				frame(625);
				chk(n, 2 * (k > 4 + i ? 4 + i : k));
				if (k != 0) chk(tr, k % 3);
			end
		end
		bus(1, `A_LAST_DATA, 32'h302);
		bus(1, `A_CTRL, 32'h30);
		for (i = 0; i < 2; i++) begin
			det <= !i;
			cyc(640);
			chk(RATE_625, !i);
			frame(i ? 525 : 625);
			chk(n, i ? 4 : 6);
		end
		det <= 1;
		$display("test data lines done");
		bus(1, `A_IRQ_STATUS, 32'hf);
		for (i = 0; i < 2; i++) begin
			bus(1, `A_CTRL, 32'h10 << i);
			bus(1, `A_IRQ_MASK, 0);
			if (i) ref_in <= 0;
			else vid <= 0;
			cyc(8);
			chk({REF_LOS_REPORT, VID_LOS_REPORT}, 1 << i);
			chk(IRQ, 0);
			bus(1, `A_IRQ_MASK, 1 << i);
			cyc(1);
			chk(IRQ, 1);
			bus(1, `A_IRQ_STATUS, 1 << i);
			cyc(1);
			chk(IRQ, 0);
			bus(1, `A_CTRL, 0);
			cyc(2);
			chk({REF_LOS_REPORT, VID_LOS_REPORT}, 0);
			bus(0, `A_STATUS, 0);
			chk(rd[3:2], i ? 0 : 2);
		end
		vid <= 1;
		ref_in <= 1;
		$display("test loss done");
		for (i = 0; i < 2; i++) begin
			bus(1, `A_CTRL, i ? 32'h0 : 32'hc);
			cyc(10);
			chk(FLYWHEEL_ON, i);
			cyc(15);
			chk(FLYWHEEL_ON, !i);
			chk(FRAME_SYNC_MODE, i);
			sw <= 1;
			cyc(1);
			sw <= 0;
			cyc(3);
			chk(AUDIO_MUTE, !i);
			cyc(12);
			chk(AUDIO_MUTE, 0);
		end
		$display("test timing done");
		end_of_test;
	end
	initial begin
		#400000;
		fail_count++;
		$display("BAD %0t watchdog", $time);
		end_of_test;
	end
endmodule // vid_in_select_tb
`default_nettype wire
